/* File: logic/card_cmd_pkg.sv */
package card_cmd_pkg;

	localparam int DATA_W  = 32;
	localparam int PADDR_W = 8;

	localparam logic [PADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [PADDR_W-1:0] OFS_CMD    = 8'h04;
	localparam logic [PADDR_W-1:0] OFS_FILE   = 8'h08;
	localparam logic [PADDR_W-1:0] OFS_GEOM   = 8'h0C;
	localparam logic [PADDR_W-1:0] OFS_STAT   = 8'h10;
	localparam logic [PADDR_W-1:0] OFS_DATA   = 8'h14;
	localparam logic [PADDR_W-1:0] OFS_OFFSET = 8'h18;

	localparam int CTRL_START_BIT = 0;

	localparam logic [7:0] P1_STAT_NONE   = 8'h00;
	localparam logic [7:0] P1_STAT_INIT   = 8'h01;
	localparam logic [7:0] P1_STAT_TERM   = 8'h02;
	localparam logic [7:0] P2_STAT_SELECT = 8'h00;
	localparam logic [7:0] P2_STAT_NAME   = 8'h01;
	localparam logic [7:0] P2_STAT_NODATA = 8'h0C;

	localparam logic [2:0] P1_SFI_TAG   = 3'b100;
	localparam logic [4:0] SFI_CURRENT  = 5'h00;
	localparam logic [4:0] SFI_RESERVED = 5'h1F;
	localparam logic [2:0] MODE_NEXT    = 3'b010;
	localparam logic [2:0] MODE_PREV    = 3'b011;
	localparam logic [2:0] MODE_ABS     = 3'b100;
	localparam logic [7:0] REC_CURRENT  = 8'h00;
	localparam logic [7:0] FIRST_REC    = 8'h01;
	localparam logic [8:0] LE_MAX       = 9'h100;

	typedef enum logic [1:0] {OP_STATUS, OP_READ_BIN, OP_UPDATE_BIN, OP_READ_REC} op_e;
	typedef enum logic [1:0] {FS_TRANSPARENT, FS_LINEAR, FS_CYCLIC} fstruct_e;
	typedef enum logic [1:0] {APP_NONE, APP_INIT, APP_TERM} app_e;
	typedef enum logic [1:0] {RESP_SELECT, RESP_NAME, RESP_NONE} resp_e;
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} state_e;
	typedef enum logic [3:0] {
		ERR_NONE, ERR_RESERVED, ERR_ACCESS, ERR_NOT_FOUND, ERR_FILE_TYPE,
		ERR_RANGE, ERR_LENGTH, ERR_NO_POINTER, ERR_EOF
	} err_e;

	typedef struct packed {
		logic [5:0] rsvd;
		op_e        op;
		logic [7:0] len;
		logic [7:0] p2;
		logic [7:0] p1;
	} cmd_s;

	typedef struct packed {
		logic [15:0] fid;
		logic [2:0]  rsvd_hi;
		logic [4:0]  short_file_id;
		logic [2:0]  rsvd_lo;
		logic        sfi_present;
		logic        upd_ok;
		logic        rd_ok;
		fstruct_e    fstruct;
	} file_s;

	typedef struct packed {
		logic [15:0] size;
		logic [7:0]  reclen;
		logic [7:0]  nrec;
	} geom_s;

	typedef struct packed {
		logic [3:0] rsvd;
		logic [8:0] remain;
		logic [7:0] ptr;
		logic       ptr_valid;
		app_e       app;
		resp_e      kind;
		err_e       err;
		logic       done;
		logic       busy;
	} stat_s;

endpackage

/* File: logic/card_file_access_cmds.sv */
`timescale 1ns/1ns
module card_file_access_cmds
	import card_cmd_pkg::*;
#(
	parameter int MEM_BYTES = 64
) (
	input  wire logic               CLK,
	input  wire logic               RSTN,
	input  wire logic [PADDR_W-1:0] PADDR,
	input  wire logic               PSEL,
	input  wire logic               PENABLE,
	input  wire logic               PWRITE,
	input  wire logic [DATA_W-1:0]  PWDATA,
	output logic      [DATA_W-1:0]  PRDATA,
	output logic                    PREADY,
	output logic                    PSLVERR
);

	localparam int          AW        = $clog2(MEM_BYTES);
	localparam logic [16:0] MEM_LIMIT = 17'(MEM_BYTES);
	// byte and record counts that the transfer logic compares against or steps by
	localparam logic [8:0]  ONE_LEFT   = 9'h001;
	localparam logic [8:0]  NO_BYTES   = 9'h000;
	localparam logic [7:0]  COUNT_ZERO = 8'h00;
	localparam logic [7:0]  REC_STEP   = 8'h01;

	typedef struct packed {
		state_e                       st;
		logic [MEM_BYTES-1:0][7:0]    mem;
		cmd_s                         cmd;
		file_s                        file;
		geom_s                        geom;
		logic [7:0]                   ptr;
		logic                         ptr_valid;
		app_e                         app;
		resp_e                        kind;
		err_e                         err;
		logic                         done;
		logic [AW-1:0]                addr;
		logic [15:0]                  offset;
		logic [8:0]                   remain;
		logic [DATA_W-1:0]            prdata;
		logic                         slverr;
	} regs_s;

	regs_s r_q;
	regs_s r_d;

	// byte position of a record; numbering starts at one
	function automatic logic [16:0] rec_base(input logic [7:0] rec, input logic [7:0] len);
		rec_base = 17'(({9'h000, rec} - 17'h00001) * {9'h000, len});
	endfunction

	// a transfer may not run past the file nor past the storage behind it
	function automatic logic past_end(input logic [16:0] pos, input logic [15:0] size);
		past_end = (pos > {1'b0, size}) || (pos > MEM_LIMIT);
	endfunction

	// the byte being moved is the last one of the transfer
	function automatic logic last_byte(input logic [8:0] left);
		last_byte = (left == ONE_LEFT);
	endfunction

	// a short id reference must name the one selected file
	function automatic logic sfi_miss(input logic [4:0] req, input logic [4:0] eff);
		sfi_miss = (req != eff);
	endfunction

	logic         setup;
	logic         acc;
	logic         start;
	err_e         e;
	logic [15:0]  off;
	logic [8:0]   n;
	logic [7:0]   rec;
	logic [16:0]  end_pos;
	logic [16:0]  base;
	logic [4:0]   sfi_eff;
	logic         sfi_ref;
	logic [4:0]   sfi_req;
	logic         move;
	logic [2:0]   mode;
	stat_s        stat;

	always_comb begin
		r_d     = r_q;
		e       = ERR_NONE;
		off     = '0;
		n       = '0;
		rec     = '0;
		end_pos = '0;
		base    = '0;
		sfi_ref = 1'b0;
		sfi_req = '0;
		move    = 1'b0;
		mode    = r_q.cmd.p2[2:0];
		setup   = PSEL & ~PENABLE;
		acc     = PSEL & PENABLE;
		start   = acc & PWRITE & (PADDR == OFS_CTRL) & PWDATA[CTRL_START_BIT]
			& (r_q.st == ST_IDLE);
		// a file without an explicit short id answers to its identifier's low bits
		sfi_eff = r_q.file.sfi_present ? r_q.file.short_file_id : r_q.file.fid[4:0];

		stat           = '0;
		stat.remain    = r_q.remain;
		stat.ptr       = r_q.ptr;
		stat.ptr_valid = r_q.ptr_valid;
		stat.app       = r_q.app;
		stat.kind      = r_q.kind;
		stat.err       = r_q.err;
		stat.done      = r_q.done;
		stat.busy      = (r_q.st != ST_IDLE);

		// read data is captured in setup so the access phase needs no wait
		if (setup) begin
			r_d.slverr = 1'b0;
			r_d.prdata = '0;
			if (PADDR == OFS_CTRL) begin
				r_d.prdata = '0;
			end else if (PADDR == OFS_CMD) begin
				r_d.prdata = r_q.cmd;
			end else if (PADDR == OFS_FILE) begin
				r_d.prdata = r_q.file;
			end else if (PADDR == OFS_GEOM) begin
				r_d.prdata = r_q.geom;
			end else if (PADDR == OFS_STAT) begin
				r_d.prdata = stat;
			end else if (PADDR == OFS_DATA) begin
				if (r_q.st == ST_READ) begin
					r_d.prdata = {24'h000000, r_q.mem[r_q.addr]};
				end
			end else if (PADDR == OFS_OFFSET) begin
				r_d.prdata = {16'h0000, r_q.offset};
			end else begin
				r_d.slverr = 1'b1;
			end
		end

		// writes land at the access edge; reads were captured a cycle earlier
		if (acc && PWRITE) begin
			if (PADDR == OFS_CMD) begin
				r_d.cmd      = cmd_s'(PWDATA);
				r_d.cmd.rsvd = '0;
			end else if (PADDR == OFS_FILE) begin
				r_d.file         = file_s'(PWDATA);
				r_d.file.rsvd_hi = '0;
				r_d.file.rsvd_lo = '0;
				// new file selected: its pointer starts unset
				r_d.ptr_valid    = 1'b0;
				r_d.ptr          = '0;
			end else if (PADDR == OFS_GEOM) begin
				r_d.geom = geom_s'(PWDATA);
			end else if (PADDR == OFS_DATA && r_q.st == ST_WRITE) begin
				r_d.mem[r_q.addr] = PWDATA[7:0];
				r_d.addr          = r_q.addr + 1'b1;
				r_d.remain        = r_q.remain - ONE_LEFT;
				if (last_byte(r_q.remain)) begin
					r_d.st   = ST_IDLE;
					r_d.done = 1'b1;
				end
			end
		end

		// each read of the data window in ST_READ hands out one byte
		if (acc && !PWRITE && PADDR == OFS_DATA && r_q.st == ST_READ) begin
			r_d.addr   = r_q.addr + 1'b1;
			r_d.remain = r_q.remain - ONE_LEFT;
			if (last_byte(r_q.remain)) begin
				r_d.st   = ST_IDLE;
				r_d.done = 1'b1;
			end
		end

		// start is ignored while busy so a stray strobe cannot restart a transfer
		if (start) begin
			case (r_q.cmd.op)
				OP_STATUS: begin
					if (r_q.cmd.p1 != P1_STAT_NONE && r_q.cmd.p1 != P1_STAT_INIT
						&& r_q.cmd.p1 != P1_STAT_TERM) begin
						e = ERR_RESERVED;
					end else if (r_q.cmd.p2 != P2_STAT_SELECT && r_q.cmd.p2 != P2_STAT_NAME
						&& r_q.cmd.p2 != P2_STAT_NODATA) begin
						e = ERR_RESERVED;
					end else begin
						if (r_q.cmd.p1 == P1_STAT_INIT) begin
							r_d.app = APP_INIT;
						end else if (r_q.cmd.p1 == P1_STAT_TERM) begin
							r_d.app = APP_TERM;
						end
						// response content itself is assembled by firmware
						if (r_q.cmd.p2 == P2_STAT_SELECT) begin
							r_d.kind = RESP_SELECT;
						end else if (r_q.cmd.p2 == P2_STAT_NAME) begin
							r_d.kind = RESP_NAME;
						end else begin
							r_d.kind = RESP_NONE;
						end
					end
				end
				OP_READ_BIN, OP_UPDATE_BIN: begin
					if (!r_q.cmd.p1[7]) begin
						off = {1'b0, r_q.cmd.p1[6:0], r_q.cmd.p2};
					end else if (r_q.cmd.p1[7:5] == P1_SFI_TAG) begin
						sfi_ref = 1'b1;
						sfi_req = r_q.cmd.p1[4:0];
						off     = {8'h00, r_q.cmd.p2};
					end else begin
						e = ERR_RESERVED;
					end
					// a zero expected length on a read means the maximum short length
					if (r_q.cmd.op == OP_READ_BIN && r_q.cmd.len == COUNT_ZERO) begin
						n = LE_MAX;
					end else begin
						n = {1'b0, r_q.cmd.len};
					end
					end_pos = {1'b0, off} + {8'h00, n};
					if (e == ERR_NONE) begin
						if (sfi_ref && sfi_miss(sfi_req, sfi_eff)) begin
							e = ERR_NOT_FOUND;
						end else if (r_q.file.fstruct != FS_TRANSPARENT) begin
							e = ERR_FILE_TYPE;
						end else if (r_q.cmd.op == OP_READ_BIN && !r_q.file.rd_ok) begin
							e = ERR_ACCESS;
						end else if (r_q.cmd.op == OP_UPDATE_BIN && !r_q.file.upd_ok) begin
							e = ERR_ACCESS;
						end else if (past_end(end_pos, r_q.geom.size)) begin
							e = ERR_RANGE;
						end
					end
					if (e == ERR_NONE) begin
						r_d.offset = off;
						r_d.addr   = off[AW-1:0];
						r_d.remain = n;
						if (n == NO_BYTES) begin
							r_d.st = ST_IDLE;
						end else if (r_q.cmd.op == OP_READ_BIN) begin
							r_d.st = ST_READ;
						end else begin
							r_d.st = ST_WRITE;
						end
					end
				end
				// the pointer target is chosen here and kept only if the read is accepted
				OP_READ_REC: begin
					sfi_req = r_q.cmd.p2[7:3];
					if (sfi_req == SFI_RESERVED || (mode != MODE_NEXT && mode != MODE_PREV
						&& mode != MODE_ABS)) begin
						e = ERR_RESERVED;
					end else if (sfi_req != SFI_CURRENT && sfi_miss(sfi_req, sfi_eff)) begin
						e = ERR_NOT_FOUND;
					end else if (r_q.file.fstruct != FS_LINEAR
						&& r_q.file.fstruct != FS_CYCLIC) begin
						e = ERR_FILE_TYPE;
					end else if (!r_q.file.rd_ok) begin
						e = ERR_ACCESS;
					end else if (r_q.cmd.len != r_q.geom.reclen) begin
						e = ERR_LENGTH;
					end else if (r_q.geom.nrec == COUNT_ZERO) begin
						e = ERR_RANGE;
					end else if (mode == MODE_ABS) begin
						if (r_q.cmd.p1 == REC_CURRENT) begin
							if (!r_q.ptr_valid) begin
								e = ERR_NO_POINTER;
							end else begin
								rec = r_q.ptr;
							end
						end else if (r_q.cmd.p1 > r_q.geom.nrec) begin
							e = ERR_RANGE;
						end else begin
							rec = r_q.cmd.p1;
						end
					end else if (mode == MODE_NEXT) begin
						move = 1'b1;
						if (!r_q.ptr_valid) begin
							rec = FIRST_REC;
						end else if (r_q.ptr >= r_q.geom.nrec) begin
							if (r_q.file.fstruct == FS_CYCLIC) begin
								rec = FIRST_REC;
							end else begin
								e = ERR_EOF;
							end
						end else begin
							rec = r_q.ptr + REC_STEP;
						end
					end else begin
						move = 1'b1;
						if (!r_q.ptr_valid) begin
							rec = r_q.geom.nrec;
						end else if (r_q.ptr <= FIRST_REC) begin
							if (r_q.file.fstruct == FS_CYCLIC) begin
								rec = r_q.geom.nrec;
							end else begin
								e = ERR_EOF;
							end
						end else begin
							rec = r_q.ptr - REC_STEP;
						end
					end
					if (e == ERR_NONE) begin
						base    = rec_base(rec, r_q.geom.reclen);
						off     = base[15:0];
						end_pos = base + {9'h000, r_q.geom.reclen};
						if (past_end(end_pos, r_q.geom.size)) begin
							e = ERR_RANGE;
						end
					end
					if (e == ERR_NONE) begin
						r_d.offset = off;
						r_d.addr   = off[AW-1:0];
						r_d.remain = {1'b0, r_q.cmd.len};
						r_d.st     = (r_q.cmd.len == COUNT_ZERO) ? ST_IDLE : ST_READ;
						// pointer follows only a read that will succeed
						if (move) begin
							r_d.ptr       = rec;
							r_d.ptr_valid = 1'b1;
						end
					end
				end
				default: begin
					e = ERR_RESERVED;
				end
			endcase
			r_d.err = e;
			// done at once unless bytes are still to move
			r_d.done = (e != ERR_NONE) || (r_d.st == ST_IDLE);
			// a refused command leaves the data window closed
			if (e != ERR_NONE) begin
				r_d.st     = ST_IDLE;
				r_d.remain = '0;
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign PRDATA  = r_q.prdata;
	// no wait states: every register answers in its first access cycle
	assign PREADY  = 1'b1;
	// error only shows in the access phase that it belongs to
	assign PSLVERR = acc & r_q.slverr;

endmodule

/* File: dv/card_file_access_cmds_assertions.sv */
`timescale 1ns/1ns
module card_file_access_cmds_checker
	import card_cmd_pkg::*;
#(
	parameter int MEM_BYTES = 64
) (
	input wire logic               CLK,
	input wire logic               RSTN,
	input wire logic [PADDR_W-1:0] PADDR,
	input wire logic               PSEL,
	input wire logic               PENABLE,
	input wire logic               PWRITE,
	input wire logic [DATA_W-1:0]  PWDATA,
	input wire logic [DATA_W-1:0]  PRDATA,
	input wire logic               PREADY,
	input wire logic               PSLVERR
);
	logic [25:0] cmd_q;
	logic        rsv_q;
	logic        bad;

	// status command with any reserved parameter byte
	assign bad = cmd_q[7:0] > P1_STAT_TERM
		|| !(cmd_q[15:8] inside {P2_STAT_SELECT, P2_STAT_NAME, P2_STAT_NODATA});

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cmd_q <= '0;
			rsv_q <= 1'b0;
		end else if (PSEL && PENABLE && PWRITE) begin
			if (PADDR == OFS_CMD)
				cmd_q <= PWDATA[25:0];
			rsv_q <= PADDR == OFS_CTRL && PWDATA[0] && cmd_q[25:24] == OP_STATUS && bad;
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);

	sequence s_acc;
		PSEL && PENABLE;
	endsequence
	sequence s_rd(a);
		PSEL && PENABLE && !PWRITE && PADDR == a;
	endsequence

	chk_err_unmap: assert property (s_acc ##0 PADDR > OFS_OFFSET |-> PSLVERR)
		else $error("unmapped access without slave error");
	chk_err_mapped: assert property (s_acc ##0 (PADDR <= OFS_OFFSET && PADDR[1:0] == 2'h0)
		|-> !PSLVERR)
		else $error("slave error on a mapped register");
	chk_err_phase: assert property (PSLVERR |-> PSEL && PENABLE)
		else $error("slave error outside access phase");
	chk_unmap_data: assert property (s_rd(8'h40) |-> PRDATA == 32'h00000000)
		else $error("unmapped read returns data");
	chk_stat_rsv: assert property (s_rd(OFS_STAT) ##0 rsv_q |-> PRDATA[5:2] == ERR_RESERVED)
		else $error("reserved status encoding not flagged");
	chk_cmd_echo: assert property (s_rd(OFS_CMD) |-> PRDATA == {6'h00, cmd_q})
		else $error("command word readback differs");
	chk_data_hold: assert property (s_acc |=> $stable(PRDATA))
		else $error("read data moved after access");
	chk_ptr_range: assert property (s_rd(OFS_STAT) ##0 PRDATA[10] |-> PRDATA[18:11] != 8'h00)
		else $error("valid pointer names record zero");
endmodule

bind card_file_access_cmds card_file_access_cmds_checker #(.MEM_BYTES(MEM_BYTES)) chk_i (
	.CLK    (CLK),
	.RSTN   (RSTN),
	.PADDR  (PADDR),
	.PSEL   (PSEL),
	.PENABLE(PENABLE),
	.PWRITE (PWRITE),
	.PWDATA (PWDATA),
	.PRDATA (PRDATA),
	.PREADY (PREADY),
	.PSLVERR(PSLVERR)
);

/* File: dv/apb_terminal.sv */
`timescale 1ns/1ns
module apb_terminal
	import card_cmd_pkg::*;
(
	input  wire logic               clk,
	output logic      [PADDR_W-1:0] paddr,
	output logic                    psel,
	output logic                    penable,
	output logic                    pwrite,
	output logic      [DATA_W-1:0]  pwdata,
	input  wire logic [DATA_W-1:0]  prdata,
	input  wire logic               pready
);
	initial begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h00000000;
	end

	task xfer(input logic w, input logic [PADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] r);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// released address and data lines show the inverse of the last value, never the value itself
		paddr <= ~a;
		pwdata <= ~d;
	endtask

	// next and previous record reads always carry P1 as zero, whatever p1 is given
	task go(input op_e op, input logic [7:0] p1, p2, n);
		logic [DATA_W-1:0] r;
		logic [7:0]        q;
		q = (op == OP_READ_REC && p2[2:1] == 2'b01) ? 8'h00 : p1;
		xfer(1'b1, OFS_CMD, {6'h00, op, n, p2, q}, r);
		xfer(1'b1, OFS_CTRL, 32'h00000001, r);
	endtask
endmodule

/* File: dv/test_card_file_access_cmds.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module test_card_file_access_cmds
	import card_cmd_pkg::*;
;
	logic               clk;
	logic               rstn;
	logic [PADDR_W-1:0] paddr;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [DATA_W-1:0]  pwdata;
	logic [DATA_W-1:0]  prdata;
	logic               pready;
	logic [DATA_W-1:0]  r;
	logic [DATA_W-1:0]  s;
	int                 err_count = 0;
	int                 num_checks = 0;
	logic [7:0]         p1s[3] = '{P1_STAT_INIT, P1_STAT_NONE, P1_STAT_TERM};
	logic [7:0]         p2s[3] = '{P2_STAT_NAME, P2_STAT_SELECT, P2_STAT_NODATA};
	logic [3:0]         exps[3] = '{{APP_INIT, RESP_NAME}, {APP_INIT, RESP_SELECT},
		{APP_TERM, RESP_NONE}};

	card_file_access_cmds #(.MEM_BYTES(64)) dut (
		.CLK    (clk),
		.RSTN   (rstn),
		.PADDR  (paddr),
		.PSEL   (psel),
		.PENABLE(penable),
		.PWRITE (pwrite),
		.PWDATA (pwdata),
		.PRDATA (prdata),
		.PREADY (pready),
		.PSLVERR()
	);
	apb_terminal term (
		.clk    (clk),
		.paddr  (paddr),
		.psel   (psel),
		.penable(penable),
		.pwrite (pwrite),
		.pwdata (pwdata),
		.prdata (prdata),
		.pready (pready)
	);

	initial clk = 1'b0;
	always #5 clk = ~clk;

	task wr(input logic [7:0] a, input logic [31:0] d);
		term.xfer(1'b1, a, d, r);
	endtask
	task rd(input logic [7:0] a);
		term.xfer(1'b0, a, 32'h00000000, r);
	endtask

	// one command: start it, move the bytes, then judge status
	task xact(input op_e op, input logic [7:0] p1, p2, n, input err_e e, input logic [7:0] b);
		term.go(op, p1, p2, n);
		for (int i = 0; i < n && e == ERR_NONE; i++) begin
			if (op == OP_UPDATE_BIN)
				wr(OFS_DATA, {24'h000000, b + 8'(i)});
			else begin
				rd(OFS_DATA);
				`CHK(r[7:0], b + 8'(i))
			end
		end
		rd(OFS_STAT);
		s = r;
		`CHK(s[5:0], {e, 2'b10})
	endtask
	task rec(input logic [7:0] p2, n, input err_e e, input logic [7:0] p, k);
		xact(OP_READ_REC, 8'h00, p2, n, e, 8'h0E + {k[6:0], 1'b0});
		`CHK(s[18:11], p)
	endtask
	task absr(input logic [7:0] k);
		xact(OP_READ_REC, k, MODE_ABS, 8'h02, ERR_NONE, 8'h0E + {k[6:0], 1'b0});
		`CHK(s[18:11], 8'h02)
	endtask

	task t_status;
		for (int i = 0; i < 3; i++) begin
			xact(OP_STATUS, p1s[i], p2s[i], 8'h00, ERR_NONE, 8'h00);
			`CHK(s[9:6], exps[i])
		end
		xact(OP_STATUS, 8'h03, 8'h00, 8'h00, ERR_RESERVED, 8'h00);
		xact(OP_STATUS, 8'h00, 8'h02, 8'h00, ERR_RESERVED, 8'h00);
		`CHK(s[9:8], APP_TERM)
		rd(OFS_CMD);
		`CHK(r, 32'h00000200)
	endtask

	task t_bin;
		wr(OFS_GEOM, 32'h00400203);
		wr(OFS_FILE, 32'h1234000C);
		xact(OP_UPDATE_BIN, 8'h00, 8'h00, 8'h06, ERR_NONE, 8'h10);
		xact(OP_READ_BIN, 8'h00, 8'h02, 8'h03, ERR_NONE, 8'h12);
		xact(OP_READ_BIN, 8'h94, 8'h01, 8'h02, ERR_NONE, 8'h11);
		rd(OFS_OFFSET);
		`CHK(r, 32'h00000001)
		xact(OP_READ_BIN, 8'h01, 8'h00, 8'h01, ERR_RANGE, 8'h00);
		xact(OP_READ_BIN, 8'h95, 8'h00, 8'h01, ERR_NOT_FOUND, 8'h00);
		xact(OP_READ_BIN, 8'h00, 8'h00, 8'h00, ERR_RANGE, 8'h00);
		wr(OFS_FILE, 32'h12340008);
		xact(OP_READ_BIN, 8'h00, 8'h00, 8'h01, ERR_ACCESS, 8'h00);
		wr(OFS_FILE, 32'h12340004);
		xact(OP_UPDATE_BIN, 8'h00, 8'h00, 8'h01, ERR_ACCESS, 8'h00);
		wr(OFS_FILE, 32'h12340005);
		xact(OP_READ_BIN, 8'h00, 8'h00, 8'h01, ERR_FILE_TYPE, 8'h00);
	endtask

	task t_linear;
		rec(MODE_NEXT, 8'h02, ERR_NONE, 8'h01, 8'h01);
		rec(8'hA2, 8'h02, ERR_NONE, 8'h02, 8'h02);
		rec(MODE_NEXT, 8'h02, ERR_NONE, 8'h03, 8'h03);
		rec(MODE_NEXT, 8'h02, ERR_EOF, 8'h03, 8'h00);
		rec(MODE_PREV, 8'h02, ERR_NONE, 8'h02, 8'h02);
		absr(8'h01);
		rec(MODE_ABS, 8'h02, ERR_NONE, 8'h02, 8'h02);
		rec(MODE_NEXT, 8'h03, ERR_LENGTH, 8'h02, 8'h00);
		rec(MODE_PREV, 8'h02, ERR_NONE, 8'h01, 8'h01);
		rec(MODE_PREV, 8'h02, ERR_EOF, 8'h01, 8'h00);
		rec(8'h07, 8'h02, ERR_RESERVED, 8'h01, 8'h00);
		rec(8'hFA, 8'h02, ERR_RESERVED, 8'h01, 8'h00);
	endtask

	task t_cyclic;
		wr(OFS_FILE, 32'h12340006);
		rec(MODE_ABS, 8'h02, ERR_NO_POINTER, 8'h00, 8'h00);
		rec(MODE_PREV, 8'h02, ERR_NONE, 8'h03, 8'h03);
		rec(MODE_NEXT, 8'h02, ERR_NONE, 8'h01, 8'h01);
		rec(MODE_PREV, 8'h02, ERR_NONE, 8'h03, 8'h03);
		rd(8'h40);
		`CHK(r, 32'h00000000)
	endtask

	task wrap_up;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// about 410 cycles expected; generous margin
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up();
	end

	initial begin
		rstn = 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_status();
		t_bin();
		t_linear();
		t_cyclic();
		wrap_up();
	end
endmodule
